// ===== rtl/csd_pkg.sv
// Shared constants and types for the chip-select address decoder
package csd_pkg;
   localparam int NSEL = 4;
   localparam int AXI_AW = 12;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_LOWER [NSEL] = '{10'h0a8, 10'h0ab, 10'h0ae, 10'h0b1};
   localparam logic [9:0] IDX_UPPER [NSEL] = '{10'h0a9, 10'h0ac, 10'h0af, 10'h0b2};
   localparam logic [9:0] IDX_CTL [NSEL] = '{10'h0aa, 10'h0ad, 10'h0b0, 10'h0b3};
   localparam logic [9:0] IDX_MODE [NSEL] = '{10'h0f0, 10'h0f1, 10'h0f2, 10'h0f3};
   // Reset values
   localparam logic [7:0] LOWER_RST [NSEL] = '{8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] UPPER_RST [NSEL] = '{8'hff, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] CTL_RST [NSEL] = '{8'he8, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] MODE_RST = 8'h02;
   // Field positions and writable masks
   localparam int EN_BIT = 3;
   localparam int IO_BIT = 4;
   localparam int MODE_MSB = 7;
   localparam int MODE_LSB = 6;
   localparam logic [7:0] CTL_WMASK = 8'hf8;
   localparam logic [7:0] MODE_WMASK = 8'hef;
   // Bus protocol modes
   localparam logic [1:0] MODE_NATIVE = 2'h0;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [23:0] addr;
      logic io;
   } acc_req_t;

   typedef struct packed {
      logic [7:0] lower;
      logic [7:0] upper;
      logic en;
      logic io;
   } sel_cfg_t;
endpackage : csd_pkg

// ===== rtl/select_decode.sv
// One chip-select comparator: memory range or I/O equality
`timescale 1ns/100ps
`default_nettype none
module select_decode (
   // Configuration
   input wire csd_pkg::sel_cfg_t cfg,
   // Access
   input wire csd_pkg::acc_req_t req,
   // Result
   output logic hit
);
   import csd_pkg::*;

   always_comb begin
      hit = 1'b0;
      if (cfg.en) begin
         if (cfg.io) begin
            // Upper bound not consulted here
            hit = req.io && (req.addr[15:8] == cfg.lower);
         end else begin
            hit = !req.io && (req.addr[23:16] >= cfg.lower)
               && (req.addr[23:16] <= cfg.upper);
         end
      end
   end
endmodule : select_decode
`default_nettype wire

// ===== rtl/mode_switch.sv
// Remembers the last bus mode and flags a switch penalty
`timescale 1ns/100ps
`default_nettype none
module mode_switch (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // New access
   input wire logic take,
   input wire logic [1:0] mode,
   // Penalty for this access
   output logic penalty
);
   import csd_pkg::*;

   logic [1:0] prev_q;
   logic [1:0] prev_d;

   // Entering native mode never costs a cycle
   assign penalty = (mode != prev_q) && (mode != MODE_NATIVE);

   always_comb begin
      prev_d = prev_q;
      if (take) begin
         prev_d = mode;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_q <= MODE_NATIVE;
      end else begin
         prev_q <= prev_d;
      end
   end
endmodule : mode_switch
`default_nettype wire

// ===== rtl/chip_select_address_decoder.sv
// Chip-select address decoder with bus-mode switch penalty
//
// Behaviour
// - An access in a different, non-native bus mode from the last one starts one clock later.
// - Same-mode accesses and switches into native mode start with no extra clock.
// - A memory select compares address bits 23:16 against its lower bound.
// - An I/O select fires only when address bits 15:8 equal its lower bound.
// - A disabled select is never asserted.
// - All lower-bound registers reset to zero.
// - A memory select compares address bits 23:16 against its upper bound.
// - The upper bound has no effect on an I/O select.
// - Upper bound of select 0 resets to all ones, the others to zero.
// - The type bit picks memory decoding at zero and I/O decoding at one.
// - Control bit 3 enables the select.
// - Control bit 4 sets I/O type, clear means memory type.
`timescale 1ns/100ps
`default_nettype none
module chip_select_address_decoder (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [csd_pkg::AXI_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [csd_pkg::AXI_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Access request
   input wire logic acc_valid,
   input wire csd_pkg::acc_req_t acc_req,
   output logic acc_ready,
   // Access start
   output logic [csd_pkg::NSEL-1:0] select_q,
   output logic [1:0] mode_q,
   output logic start_q
);
   import csd_pkg::*;

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_GAP = 2'b10
   } acc_state_t;

   // Register file
   logic [7:0] lower_q [NSEL];
   logic [7:0] lower_d [NSEL];
   logic [7:0] upper_q [NSEL];
   logic [7:0] upper_d [NSEL];
   logic [7:0] ctl_q [NSEL];
   logic [7:0] ctl_d [NSEL];
   logic [7:0] bmode_q [NSEL];
   logic [7:0] bmode_d [NSEL];

   // Bus slave state
   logic aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic [9:0] widx_q, widx_d;
   logic [7:0] wbyte_q, wbyte_d;
   logic wlane_q, wlane_d;
   logic awready_q, awready_d, wready_q, wready_d;
   logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic do_write, take_ar, wr_hit, rd_hit;
   logic [7:0] rd_byte;
   logic [9:0] ridx;

   assign ridx = araddr[AXI_AW-1:2];
   assign do_write = aw_full_q && w_full_q && !bvalid_q;
   assign take_ar = arvalid && arready_q;

   always_comb begin
      lower_d = lower_q;
      upper_d = upper_q;
      ctl_d = ctl_q;
      bmode_d = bmode_q;
      wr_hit = 1'b0;
      rd_hit = 1'b0;
      rd_byte = 8'h00;
      for (int k = 0; k < NSEL; k++) begin
         if (widx_q == IDX_LOWER[k] || widx_q == IDX_UPPER[k]
            || widx_q == IDX_CTL[k] || widx_q == IDX_MODE[k]) begin
            wr_hit = 1'b1;
         end
         if (do_write && wlane_q) begin
            if (widx_q == IDX_LOWER[k]) lower_d[k] = wbyte_q;
            if (widx_q == IDX_UPPER[k]) upper_d[k] = wbyte_q;
            if (widx_q == IDX_CTL[k]) ctl_d[k] = wbyte_q & CTL_WMASK;
            if (widx_q == IDX_MODE[k]) bmode_d[k] = wbyte_q & MODE_WMASK;
         end
         // Reads are pure; nothing changes on a read
         if (ridx == IDX_LOWER[k]) begin
            rd_hit = 1'b1;
            rd_byte = lower_q[k];
         end
         if (ridx == IDX_UPPER[k]) begin
            rd_hit = 1'b1;
            rd_byte = upper_q[k];
         end
         if (ridx == IDX_CTL[k]) begin
            rd_hit = 1'b1;
            rd_byte = ctl_q[k];
         end
         if (ridx == IDX_MODE[k]) begin
            rd_hit = 1'b1;
            rd_byte = bmode_q[k];
         end
      end
   end

   always_comb begin
      aw_full_d = aw_full_q;
      w_full_d = w_full_q;
      widx_d = widx_q;
      wbyte_d = wbyte_q;
      wlane_d = wlane_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      arready_d = arready_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (awvalid && awready_q) begin
         aw_full_d = 1'b1;
         widx_d = awaddr[AXI_AW-1:2];
      end
      if (wvalid && wready_q) begin
         w_full_d = 1'b1;
         wbyte_d = wdata[7:0];
         wlane_d = wstrb[0];
      end
      if (bvalid_q && bready) begin
         bvalid_d = 1'b0;
      end
      if (do_write) begin
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
         arready_d = 1'b1;
      end
      if (take_ar) begin
         arready_d = 1'b0;
         rvalid_d = 1'b1;
         rdata_d = {24'h000000, rd_byte};
         rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      awready_d = !aw_full_d;
      wready_d = !w_full_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int k = 0; k < NSEL; k++) begin
            lower_q[k] <= LOWER_RST[k];
            upper_q[k] <= UPPER_RST[k];
            ctl_q[k] <= CTL_RST[k];
            bmode_q[k] <= MODE_RST;
         end
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         widx_q <= 10'h000;
         wbyte_q <= 8'h00;
         wlane_q <= 1'b0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h00000000;
      end else begin
         lower_q <= lower_d;
         upper_q <= upper_d;
         ctl_q <= ctl_d;
         bmode_q <= bmode_d;
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         widx_q <= widx_d;
         wbyte_q <= wbyte_d;
         wlane_q <= wlane_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;

   // Decode and start sequencing
   sel_cfg_t cfg [NSEL];
   logic [NSEL-1:0] raw, raw_q, raw_d, prio, pend_q, pend_d, select_d;
   logic [1:0] new_mode, pend_mode_q, pend_mode_d, mode_d;
   logic take, penalty, start_d, ready_q, ready_d;
   acc_state_t st_q, st_d;

   assign take = acc_valid && ready_q;

   for (genvar k = 0; k < NSEL; k++) begin : g_sel
      assign cfg[k] = '{lower: lower_q[k], upper: upper_q[k],
                        en: ctl_q[k][EN_BIT], io: ctl_q[k][IO_BIT]};
      select_decode u_dec (
         .cfg(cfg[k]),
         .req(acc_req),
         .hit(raw[k])
      );
   end

   // Overlapping selects: the lowest number wins
   always_comb begin
      prio = '0;
      new_mode = MODE_NATIVE;
      for (int k = NSEL - 1; k >= 0; k--) begin
         if (raw[k]) begin
            prio = '0;
            prio[k] = 1'b1;
            new_mode = bmode_q[k][MODE_MSB:MODE_LSB];
         end
      end
   end

   mode_switch u_mode (
      .aclk(aclk),
      .aresetn(aresetn),
      .take(take),
      .mode(new_mode),
      .penalty(penalty)
   );

   always_comb begin
      st_d = st_q;
      raw_d = raw_q;
      pend_d = pend_q;
      pend_mode_d = pend_mode_q;
      select_d = select_q;
      mode_d = mode_q;
      start_d = 1'b0;
      ready_d = ready_q;
      unique case (st_q)
         ST_RUN: begin
            if (take) begin
               raw_d = raw;
               if (penalty) begin
                  // Hold the access one clock for the mode change
                  pend_d = prio;
                  pend_mode_d = new_mode;
                  ready_d = 1'b0;
                  st_d = ST_GAP;
               end else begin
                  select_d = prio;
                  mode_d = new_mode;
                  start_d = 1'b1;
               end
            end
         end
         ST_GAP: begin
            select_d = pend_q;
            mode_d = pend_mode_q;
            start_d = 1'b1;
            ready_d = 1'b1;
            st_d = ST_RUN;
         end
         default: begin
            st_d = ST_RUN;
            ready_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= ST_RUN;
         raw_q <= '0;
         pend_q <= '0;
         pend_mode_q <= MODE_NATIVE;
         select_q <= '0;
         mode_q <= MODE_NATIVE;
         start_q <= 1'b0;
         ready_q <= 1'b1;
      end else begin
         st_q <= st_d;
         raw_q <= raw_d;
         pend_q <= pend_d;
         pend_mode_q <= pend_mode_d;
         select_q <= select_d;
         mode_q <= mode_d;
         start_q <= start_d;
         ready_q <= ready_d;
      end
   end

   assign acc_ready = ready_q;

   switch_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
      take && penalty |=> !start_q && !acc_ready ##1 start_q && acc_ready)
      else $error("mode switch did not delay start by one clock");
   same_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
      take && !penalty |=> start_q && select_q == $past(prio))
      else $error("access without switch was delayed");

   for (genvar k = 0; k < NSEL; k++) begin : g_chk
      mem_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
         take && !cfg[k].io && acc_req.addr[23:16] < cfg[k].lower |=> !raw_q[k])
         else $error("memory select active below lower bound");
      io_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
         take && cfg[k].io && acc_req.addr[15:8] != cfg[k].lower |=> !raw_q[k])
         else $error("I/O select active without address match");
      disabled_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
         take && !ctl_q[k][EN_BIT] |=> !raw_q[k] && !(start_q && select_q[k]))
         else $error("disabled select asserted");
      lower_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
         $past(!aresetn) |-> lower_q[k] == 8'h00)
         else $error("lower bound not zero after reset");
      mem_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
         take && !ctl_q[k][IO_BIT] && acc_req.addr[23:16] > upper_q[k] |=> !raw_q[k])
         else $error("memory select active above upper bound");
      io_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
         take && cfg[k].en && cfg[k].io && acc_req.io
         && acc_req.addr[15:8] == cfg[k].lower |=> raw_q[k])
         else $error("I/O select missed on matching address");
      upper_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
         $past(!aresetn) |-> upper_q[k] == ((k == 0) ? 8'hff : 8'h00))
         else $error("upper bound reset value wrong");
      mem_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
         take && cfg[k].en && !cfg[k].io && !acc_req.io
         && acc_req.addr[23:16] >= cfg[k].lower
         && acc_req.addr[23:16] <= cfg[k].upper |=> raw_q[k])
         else $error("memory select missed inside range");
      bound_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
         do_write && wlane_q && widx_q == IDX_UPPER[k] |=> upper_q[k] == $past(wbyte_q))
         else $error("upper bound did not take written value");
   end
endmodule : chip_select_address_decoder
`default_nettype wire

// ===== bench/access_partner.sv
// Access source and start monitor on the decoder's access port
`timescale 1ns/100ps
`default_nettype none
module access_partner (
   // Clock
   input wire logic aclk,
   // Access port
   output logic acc_valid,
   output var csd_pkg::acc_req_t acc_req,
   input wire logic acc_ready,
   // Start report
   input wire logic start_q,
   input wire logic [csd_pkg::NSEL-1:0] select_q,
   input wire logic [1:0] mode_q
);
   import csd_pkg::*;
   initial begin
      acc_valid = 1'b0;
      acc_req = '0;
   end
   // One access after lag idle cycles; lat stays 0 if no start is seen
   task automatic access(input logic [23:0] addr, input logic io, input int lag,
         output logic [31:0] lat, output logic [NSEL-1:0] sel, output logic [1:0] mode);
      int n;
      lat = '0;
      sel = '0;
      mode = '0;
      n = 0;
      repeat (lag) @(posedge aclk);
      @(posedge aclk);
      acc_valid <= 1'b1;
      acc_req <= {addr, io};
      do begin
         @(posedge aclk);
         n++;
      end while (acc_ready !== 1'b1 && n < 20);
      acc_valid <= 1'b0;
      // Released lines flip so stale address never looks valid
      acc_req <= ~acc_req;
      for (n = 1; n <= 4; n++) begin
         @(posedge aclk);
         if (start_q === 1'b1) begin
            lat = n;
            sel = select_q;
            mode = mode_q;
            break;
         end
      end
   endtask : access
endmodule : access_partner
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the chip-select address decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import csd_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, acc_valid, acc_ready, start_q;
   logic [AXI_AW-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, mode_q;
   logic [NSEL-1:0] select_q;
   acc_req_t acc_req;
   int errors, comparisons;

   chip_select_address_decoder DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .acc_valid(acc_valid), .acc_req(acc_req), .acc_ready(acc_ready),
      .select_q(select_q), .mode_q(mode_q), .start_q(start_q));
   access_partner partner (.aclk(aclk), .acc_valid(acc_valid), .acc_req(acc_req),
      .acc_ready(acc_ready), .start_q(start_q), .select_q(select_q), .mode_q(mode_q));

   always #12.5 aclk = ~aclk;

   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val

   task automatic summarize();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   task automatic wr(input logic [9:0] idx, input logic [7:0] val, input logic [1:0] exp);
      bit aw, w, b;
      int n;
      aw = 0;
      w = 0;
      b = 0;
      n = 0;
      @(posedge aclk);
      awaddr <= {idx, 2'h0};
      wdata <= {24'h0, val};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b) begin
         @(posedge aclk);
         if (!aw && awready === 1'b1) begin
            aw = 1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1) begin
            w = 1;
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1) begin
            b = 1;
            bready <= 1'b0;
            check_val($sformatf("bresp %h", idx), {30'h0, exp}, {30'h0, bresp});
         end
         n++;
         if (n > 30) begin
            errors++;
            summarize();
         end
      end
   endtask : wr

   task automatic rd(input logic [9:0] idx, input logic [7:0] val, input logic [1:0] exp);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
         if (n > 30) begin
            errors++;
            summarize();
         end
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      check_val($sformatf("rdata %h", idx), {24'h0, val}, rdata);
      check_val($sformatf("rresp %h", idx), {30'h0, exp}, {30'h0, rresp});
   endtask : rd

   task automatic acc(input logic [23:0] a, input logic io, input logic [3:0] s,
         input logic [1:0] m, input logic [31:0] lat);
      logic [31:0] l;
      logic [NSEL-1:0] gs;
      logic [1:0] gm;
      partner.access(a, io, 1, l, gs, gm);
      check_val($sformatf("select %h", a), {28'h0, s}, {28'h0, gs});
      check_val($sformatf("mode %h", a), {30'h0, m}, {30'h0, gm});
      check_val($sformatf("latency %h", a), lat, l);
      // No start seen within the partner's bound: treat as a hang
      if (l == '0) summarize();
   endtask : acc

   task automatic test_reset();
      // Select 0 comes out of reset enabled over the whole memory space
      rd(IDX_CTL[0], 8'he8, 2'h0);
      acc(24'h000000, 1'b0, 4'h1, 2'h0, 1);
      acc(24'hff0000, 1'b0, 4'h1, 2'h0, 1);
      for (int i = 0; i < NSEL; i++) begin
         rd(IDX_LOWER[i], 8'h00, 2'h0);
         rd(IDX_UPPER[i], (i == 0) ? 8'hff : 8'h00, 2'h0);
      end
   endtask : test_reset

   task automatic test_readback();
      for (int i = 0; i < NSEL; i++) begin
         wr(IDX_LOWER[i], 8'ha5 ^ 8'(i), 2'h0);
         wr(IDX_UPPER[i], 8'h5a ^ 8'(i), 2'h0);
      end
      for (int i = 0; i < NSEL; i++) begin
         rd(IDX_LOWER[i], 8'ha5 ^ 8'(i), 2'h0);
         rd(IDX_UPPER[i], 8'h5a ^ 8'(i), 2'h0);
      end
      // Unmapped place refuses both ways
      wr(10'h010, 8'h33, 2'h2);
      rd(10'h010, 8'h00, 2'h2);
   endtask : test_readback

   task automatic test_memory();
      wr(IDX_CTL[0], 8'h00, 2'h0);
      wr(IDX_LOWER[1], 8'h10, 2'h0);
      wr(IDX_UPPER[1], 8'h20, 2'h0);
      wr(IDX_CTL[1], 8'h08, 2'h0);
      acc(24'h0fffff, 1'b0, 4'h0, 2'h0, 1);
      acc(24'h100000, 1'b0, 4'h2, 2'h0, 1);
      acc(24'h20ffff, 1'b0, 4'h2, 2'h0, 1);
      acc(24'h210000, 1'b0, 4'h0, 2'h0, 1);
      acc(24'h150000, 1'b1, 4'h0, 2'h0, 1);
   endtask : test_memory

   task automatic test_io();
      wr(IDX_LOWER[2], 8'h55, 2'h0);
      wr(IDX_UPPER[2], 8'h00, 2'h0);
      wr(IDX_CTL[2], 8'h18, 2'h0);
      acc(24'h125500, 1'b1, 4'h4, 2'h0, 1);
      acc(24'h125400, 1'b1, 4'h0, 2'h0, 1);
      acc(24'h005500, 1'b1, 4'h4, 2'h0, 1);
      acc(24'h550000, 1'b0, 4'h0, 2'h0, 1);
   endtask : test_io

   task automatic test_disable();
      wr(IDX_CTL[1], 8'h00, 2'h0);
      acc(24'h150000, 1'b0, 4'h0, 2'h0, 1);
      wr(IDX_CTL[1], 8'h08, 2'h0);
      acc(24'h150000, 1'b0, 4'h2, 2'h0, 1);
   endtask : test_disable

   task automatic test_modes();
      wr(IDX_MODE[1], 8'h82, 2'h0);
      wr(IDX_MODE[2], 8'hc2, 2'h0);
      acc(24'h150000, 1'b0, 4'h2, 2'h2, 2);
      acc(24'h150000, 1'b0, 4'h2, 2'h2, 1);
      acc(24'h125500, 1'b1, 4'h4, 2'h3, 2);
      acc(24'h300000, 1'b0, 4'h0, 2'h0, 1);
      acc(24'h1a0000, 1'b0, 4'h2, 2'h2, 2);
   endtask : test_modes

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      errors = 0;
      comparisons = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      test_reset();
      test_readback();
      test_memory();
      test_io();
      test_disable();
      test_modes();
      summarize();
   end
endmodule : testbench
`default_nettype wire
